// *** verilog/cpwt_cfg.svh ***
// Offsets, field positions, reset values and counts of the prescaler block
`ifndef CPWT_CFG_SVH
`define CPWT_CFG_SVH
`define CPWT_ADDR_TMODE    4'h0
`define CPWT_ADDR_SYSC1    4'h1
`define CPWT_ADDR_STATUS   4'h2
`define CPWT_ADDR_MEDSEL   4'h3
`define CPWT_TB_HI_BIT     3
`define CPWT_TB_LO_BIT     2
`define CPWT_WDS_MSB       6
`define CPWT_WDS_LSB       4
`define CPWT_SYS_RST       13'h0000
`define CPWT_SUB_RST       5'h00
`define CPWT_REG_RST       8'h00
`define CPWT_WAIT_RST      15'h0000
`define CPWT_MED_FULL      7'h7F
`define CPWT_QUARTER_LAST  2'h3
`define CPWT_WAIT_8        15'h0008
`define CPWT_WAIT_16       15'h0010
`define CPWT_WAIT_256      15'h0100
`define CPWT_WAIT_1024     15'h0400
`define CPWT_WAIT_2048     15'h0800
`define CPWT_WAIT_4096     15'h1000
`define CPWT_WAIT_8192     8192
`define CPWT_WAIT_16384    16384
`endif

// *** verilog/cpwt_pkg.sv ***
// Types shared by the prescaler and wake-delay block
package cpwt_pkg;
    // Wake sequencer states
    typedef enum logic [1:0] {
        CPWT_RUN,
        CPWT_HALTED,
        CPWT_SETTLE,
        CPWT_DELAY
    } cpwt_wake_e;
    typedef logic [7:0] cpwt_byte_t;
endpackage : cpwt_pkg

// *** verilog/cpwt_top.sv ***
// System-clock and subclock prescalers with the wake standby-time counter
// Function
// - System chain is a 13-bit up-counter advancing once per system clock.
// - Reset clears the system chain; counting starts on reset release.
// - In low-power modes the system chain halts and is held at zero.
// - Software can neither read nor write the system chain count.
// - All peripherals share the system taps, each picking its own ratio.
// - In medium speed the chain input is oscillator clock over 16 to 128.
// - Subclock chain is 5 bits, clocked by the watch clock over four.
// - Reset clears the subclock chain; counting starts after reset.
// - Subclock chain keeps counting in low-power modes while subclock runs.
// - Writing both upper time-base bits as ones clears the subclock chain.
// - Subclock chain output can clock timer A as a time base.
// - Oscillator restarts when the waking interrupt is accepted.
// - CPU and peripherals wait at least eight states after clock halt.
// - Standby length comes from bits 6 to 4 of system control one.
`include "cpwt_cfg.svh"

module cpwt_top
    import cpwt_pkg::*;
#(
    parameter int SYS_W      = 13,
    parameter int SUB_W      = 5,
    parameter int WAIT_8192  = `CPWT_WAIT_8192,
    parameter int WAIT_16384 = `CPWT_WAIT_16384
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Power mode and clock status
    input  wire logic             low_power_mode,
    input  wire logic             medium_speed,
    input  wire logic             wake_accept,
    input  wire logic             osc_stable,
    input  wire logic             watch_clk_in,
    // Clock outputs
    output logic [SYS_W-1:0]      sys_taps,
    output logic [SUB_W-1:0]      sub_taps,
    output logic                  timer_a_time_base,
    output logic                  timer_a_tap,
    output logic                  osc_restart,
    output logic                  cpu_hold
);

    // ----------------------------------------------------------
    // Functions
    // ----------------------------------------------------------

    // Standby length for each select value; the two longest entries are
    // parameters so a bench can shorten them without touching the mapping.
    // Every entry is at least eight states, so no select value can release
    // the CPU on a clock that has only just come back.
    function automatic logic [14:0] wait_len(input logic [2:0] sel);
        logic [14:0] len;
        len = `CPWT_WAIT_8;
        unique case (sel)
            3'h0: len = 15'(WAIT_8192);
            3'h1: len = 15'(WAIT_16384);
            3'h2: len = `CPWT_WAIT_1024;
            3'h3: len = `CPWT_WAIT_2048;
            3'h4: len = `CPWT_WAIT_4096;
            3'h5: len = `CPWT_WAIT_8;
            3'h6: len = `CPWT_WAIT_16;
            3'h7: len = `CPWT_WAIT_256;
        endcase
        return len;
    endfunction : wait_len

    // Low-bit mask of the medium-speed predivider: 16, 32, 64 or 128
    // A contiguous mask of ones matches exactly once per predivider period;
    // a shifted mask with a hole at the bottom would match twice.
    function automatic logic [6:0] med_mask(input logic [1:0] sel);
        return `CPWT_MED_FULL >> ~sel;
    endfunction : med_mask

    // ----------------------------------------------------------
    // Registers
    // ----------------------------------------------------------

    // Software-visible registers and the read data flop
    logic [7:0]        tmode_q;
    logic [7:0]        sysc1_q;
    logic [1:0]        medsel_q;
    logic [7:0]        reg_rdata_q;
    // Divider chains and their input conditioning
    logic [SYS_W-1:0]  sys_chain_q;
    logic [SUB_W-1:0]  sub_chain_q;
    logic [6:0]        med_div_q;
    logic              watch_prev_q;
    logic [1:0]        quarter_q;
    // Wake sequencer state and standby counting
    logic [14:0]       wait_cnt_q;
    logic [14:0]       wait_len_q;
    logic              osc_restart_q;
    cpwt_wake_e        state_q;
    cpwt_wake_e        state_d;

    // Decoded strobes, steps and the select field
    logic              wr_tmode;
    logic              tb_clear;
    logic              sys_halt;
    logic              sys_step;
    logic              watch_rise;
    logic              sub_step;
    logic              wait_done;
    logic [2:0]        wake_sel;

    // Write decode
    // The clear acts on the written data, not on the stored bits, so a second
    // write of the same value clears the subclock chain again
    assign wr_tmode = reg_wr && (reg_addr == `CPWT_ADDR_TMODE);
    assign tb_clear = wr_tmode && reg_wdata[`CPWT_TB_HI_BIT]
                               && reg_wdata[`CPWT_TB_LO_BIT];
    assign wake_sel = sysc1_q[`CPWT_WDS_MSB:`CPWT_WDS_LSB];

    // Register writes; the chain counts have no address at all
    // Only the low two bits of the ratio select exist; upper write bits drop
    // Unmapped addresses are ignored so stray writes cannot disturb timing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tmode_q  <= `CPWT_REG_RST;
            sysc1_q  <= `CPWT_REG_RST;
            medsel_q <= 2'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `CPWT_ADDR_TMODE: tmode_q  <= reg_wdata;
                `CPWT_ADDR_SYSC1: sysc1_q  <= reg_wdata;
                `CPWT_ADDR_MEDSEL: medsel_q <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero when idle or unmapped
    // Forcing zero between reads keeps a stale value from looking like an answer
    // Status shows hold, halt and the sequencer state for software polling
    // no chain readback
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= `CPWT_REG_RST;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `CPWT_ADDR_TMODE:  reg_rdata_q <= tmode_q;
                `CPWT_ADDR_SYSC1:  reg_rdata_q <= sysc1_q;
                `CPWT_ADDR_STATUS: reg_rdata_q <= {4'h0, cpu_hold, sys_halt, state_q};
                `CPWT_ADDR_MEDSEL: reg_rdata_q <= {6'h00, medsel_q};
                default:           reg_rdata_q <= `CPWT_REG_RST;
            endcase
        end else begin
            reg_rdata_q <= `CPWT_REG_RST;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // ----------------------------------------------------------
    // System clock chain
    // ----------------------------------------------------------

    // Clock generator is stopped whenever the sequencer is not running
    // Halting covers the settle and delay phases too, so the chain restarts
    // from zero only once the CPU is released
    assign sys_halt = low_power_mode || (state_q != CPWT_RUN);

    // Medium-speed predivider; free-running so a ratio change takes effect
    // at the next wrap rather than restarting the count
    // Cleared while halted so every wake starts from a known phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            med_div_q <= 7'h00;
        end else if (sys_halt) begin
            med_div_q <= 7'h00;
        end else begin
            med_div_q <= med_div_q + 7'h01;
        end
    end

    assign sys_step = !medium_speed
                   || ((med_div_q & med_mask(medsel_q)) == med_mask(medsel_q));

    // System chain; tap n of the count divides the chain input by two to the n plus one
    // Limitation: in medium speed the taps divide the predivided clock
    // count once per period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_chain_q <= `CPWT_SYS_RST;
        end else if (sys_halt) begin
            sys_chain_q <= `CPWT_SYS_RST;
        end else if (sys_step) begin
            sys_chain_q <= sys_chain_q + SYS_W'(1);
        end
    end

    // Every peripheral picks its own bit; nothing here knows their ratios
    // shared taps
    assign sys_taps = sys_chain_q;

    // ----------------------------------------------------------
    // Subclock chain
    // ----------------------------------------------------------

    // Watch clock edge detect; the pin is taken as synchronous
    // The previous level resets low, matching the idle watch clock, so no
    // false edge follows reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watch_prev_q <= 1'b0;
        end else begin
            watch_prev_q <= watch_clk_in;
        end
    end
    assign watch_rise = watch_clk_in && !watch_prev_q;

    // Divide by four on watch edges; the phase is kept across a chain clear
    // watch clock over four
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quarter_q <= 2'h0;
        end else if (watch_rise) begin
            quarter_q <= quarter_q + 2'h1;
        end
    end
    assign sub_step = watch_rise && (quarter_q == `CPWT_QUARTER_LAST);

    // Subclock chain; the watch clock must stay below half the system rate
    // or edges are lost
    // no power-mode gating here; only watch edges advance it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_chain_q <= `CPWT_SUB_RST;
        end else if (tb_clear) begin
            sub_chain_q <= `CPWT_SUB_RST;
        end else if (sub_step) begin
            sub_chain_q <= sub_chain_q + SUB_W'(1);
        end
    end
    assign sub_taps = sub_chain_q;

    // Timer A clock: subclock tap as time base, else a system tap
    // The low mode bits pick the tap; the index is widened so the top
    // subclock bit is reachable instead of wrapping to bit zero
    // time base source
    assign timer_a_time_base = tmode_q[`CPWT_TB_HI_BIT];
    always_comb begin
        if (timer_a_time_base) begin
            timer_a_tap = sub_chain_q[{1'b0, tmode_q[1:0]} + 3'h1];
        end else begin
            timer_a_tap = sys_chain_q[{1'b0, tmode_q[2:0]} + 4'h5];
        end
    end

    // ----------------------------------------------------------
    // Wake sequencer
    // ----------------------------------------------------------

    // Length never drops below eight; latched when the clock is stable
    // Greater-or-equal rather than equal so a length change can never
    // leave the counter stepping past its end
    assign wait_done = (wait_cnt_q >= wait_len_q);

    // Next state: run, halted, oscillator settling, standby delay
    // Wake requests outside the halted state are ignored
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CPWT_RUN: begin
                if (low_power_mode) begin
                    state_d = CPWT_HALTED;
                end
            end
            CPWT_HALTED: begin
                if (wake_accept) begin
                    state_d = CPWT_SETTLE;
                end
            end
            CPWT_SETTLE: begin
                if (osc_stable) begin
                    state_d = CPWT_DELAY;
                end
            end
            CPWT_DELAY: begin
                if (wait_done) begin
                    state_d = CPWT_RUN;
                end
            end
        endcase
    end

    // Sequencer state; reset leaves the CPU running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= CPWT_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Standby counter; zeroed in settle so it only counts stable clock states
    // The length is reloaded on every settle cycle, so select writes after settle wait for the next wake
    // count stable states
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_cnt_q <= `CPWT_WAIT_RST;
            wait_len_q <= `CPWT_WAIT_8;
        end else if (state_q == CPWT_SETTLE) begin
            wait_cnt_q <= `CPWT_WAIT_RST;
            wait_len_q <= wait_len(wake_sel);
        end else if (state_q == CPWT_DELAY && !wait_done) begin
            wait_cnt_q <= wait_cnt_q + 15'h0001;
        end
    end

    // Restart strobe, one cycle after the accepted interrupt
    // Registered so the oscillator enable never glitches on the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_restart_q <= 1'b0;
        end else begin
            osc_restart_q <= (state_q == CPWT_HALTED) && wake_accept;
        end
    end
    assign osc_restart = osc_restart_q;

    // CPU and peripherals idle whenever the sequencer is outside RUN
    // Combinational from the state flop, so it falls in the same cycle as RUN
    // idle hold
    assign cpu_hold = (state_q != CPWT_RUN);

endmodule : cpwt_top

// *** testbench/cpwt_monitor.sv ***
// Port-level checker for the prescaler and wake-delay block
`include "cpwt_cfg.svh"
module cpwt_monitor
    import cpwt_pkg::*;
#(
    parameter int SYS_W = 13,
    parameter int SUB_W = 5
) (
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic [3:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic             low_power_mode,
    input wire logic             medium_speed,
    input wire logic             wake_accept,
    input wire logic [SYS_W-1:0] sys_taps,
    input wire logic [SUB_W-1:0] sub_taps,
    input wire logic             osc_restart,
    input wire logic             cpu_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ------------------------
    // Chain and wake timing
    // ------------------------
    AST_SYS_STEP: assert property (!low_power_mode && !medium_speed && !cpu_hold
        |=> sys_taps == SYS_W'($past(sys_taps) + 1)) else $error("system chain missed a step");
    AST_LP_HALT: assert property (low_power_mode && !cpu_hold
        |=> cpu_hold && sys_taps == `CPWT_SYS_RST) else $error("sleep did not halt the chain");
    AST_HOLD_ZERO: assert property (cpu_hold |-> sys_taps == `CPWT_SYS_RST)
        else $error("system chain moved while held");
    AST_OSC_PULSE: assert property (osc_restart |-> $past(wake_accept) && $past(cpu_hold) ##1 !osc_restart)
        else $error("restart pulse without accepted wake");
    // Too short a hold lets the CPU run on an unsettled clock
    AST_HOLD_MIN: assert property ($fell(cpu_hold) |-> $past(cpu_hold, 8))
        else $error("hold released too early");
    AST_SUB_CLR: assert property (reg_wr && reg_addr == `CPWT_ADDR_TMODE && reg_wdata[3:2] == 2'h3
        |=> sub_taps == `CPWT_SUB_RST) else $error("subclock chain not cleared");
    AST_SUB_STEP: assert property (sub_taps != $past(sub_taps)
        |-> sub_taps == SUB_W'($past(sub_taps) + 1) || sub_taps == `CPWT_SUB_RST) else $error("subclock jump");
    AST_RD_NONE: assert property (reg_rd && reg_addr > `CPWT_ADDR_MEDSEL
        |=> reg_rdata == `CPWT_REG_RST) else $error("unmapped read not zero");
endmodule : cpwt_monitor

bind cpwt_top cpwt_monitor #(.SYS_W(SYS_W), .SUB_W(SUB_W)) u_cpwt_monitor (.clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .low_power_mode, .medium_speed, .wake_accept, .sys_taps,
    .sub_taps, .osc_restart, .cpu_hold);

// *** testbench/cpwt_partner.sv ***
// Far-side model: subclock source and system oscillator start-up
module cpwt_partner #(
    parameter int HALF_W = 3
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       low_power_mode,
    input  wire logic       osc_restart,
    input  wire logic [4:0] settle_len,
    output logic            watch_clk_in,
    output logic            osc_stable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] half_q;
    logic [4:0] settle_q;
    // ------------------------
    // Subclock and oscillator
    // ------------------------
    // Subclock keeps running in every mode, well below half the system rate
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_q       <= 3'h0;
            watch_clk_in <= 1'b0;
        end else if (half_q == 3'(HALF_W - 1)) begin
            half_q       <= 3'h0;
            watch_clk_in <= ~watch_clk_in;
        end else begin
            half_q <= half_q + 3'h1;
        end
    end
    // restart on accept
    // Oscillator dies in sleep and settles a variable while after restart
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_q   <= 5'h00;
            osc_stable <= 1'b1;
        end else if (low_power_mode) begin
            osc_stable <= 1'b0;
        end else if (osc_restart) begin
            settle_q <= settle_len;
        end else if (settle_q != 5'h00) begin
            settle_q   <= settle_q - 5'h01;
            osc_stable <= settle_q == 5'h01;
        end
    end
endmodule : cpwt_partner

// *** testbench/cpwt_tb_top.sv ***
// Self-checking bench for the prescaler and wake-delay block
`include "cpwt_cfg.svh"
module cpwt_tb_top
    import cpwt_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SHORT_A = 64;
    localparam int SHORT_B = 128;
    logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
    logic        low_power_mode = 1'b0, medium_speed = 1'b0, wake_accept = 1'b0;
    logic        osc_stable, watch_clk_in, timer_a_time_base, timer_a_tap, osc_restart, cpu_hold;
    logic [3:0]  reg_addr = 4'h0;
    logic [4:0]  sub_taps, s5, settle_len = 5'h03;
    logic [12:0] sys_taps, s;
    cpwt_byte_t  reg_wdata = 8'h00, reg_rdata;
    cpwt_byte_t  exp_q[$];
    int          errors = 0, comparisons = 0, n;
    int          len[8] = '{SHORT_A, SHORT_B, 1024, 2048, 4096, 8, 16, 256};
    // ------------------------
    // Clock, design, far side
    // ------------------------
    always #12.5 clk = ~clk;
    cpwt_top #(.WAIT_8192(SHORT_A), .WAIT_16384(SHORT_B)) u_cpwt_top (.clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .low_power_mode, .medium_speed, .wake_accept, .osc_stable, .watch_clk_in,
        .sys_taps, .sub_taps, .timer_a_time_base, .timer_a_tap, .osc_restart, .cpu_hold);
    cpwt_partner u_cpwt_partner (.clk, .reset_n, .low_power_mode, .osc_restart, .settle_len, .watch_clk_in,
        .osc_stable);
    task automatic checkn(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : checkn
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    // Strobes rise one edge after the task starts, so back-to-back calls never collide
    task automatic wr(input logic [3:0] a, input cpwt_byte_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input cpwt_byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    // Counts edges until the oscillator settles or the hold drops; a stuck wait ends the run
    task automatic wait_for(input bit on_osc, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            cnt++;
        end while (!(on_osc ? osc_stable === 1'b1 : cpu_hold === 1'b0) && cnt < 5000);
        if (cnt >= 5000) begin
            errors++;
            $display("MISMATCH wait expected done seen timeout");
            final_report();
        end
    endtask : wait_for
    task automatic restart;
        reset_n        <= 1'b0;
        low_power_mode <= 1'b0;
        cyc(6);
        checkn("sub in reset", 16'h0000, 16'(sub_taps));
        reset_n <= 1'b1;
        cyc(5);
        checkn("sys after reset", 16'h0004, 16'(sys_taps));
    endtask : restart
    // Read data stand one cycle after the strobe; oldest note is compared then
    always @(posedge clk) begin
        if (rd_seen) begin
            checkn("reg_rdata", {8'h00, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX}, {8'h00, reg_rdata});
        end
        rd_seen <= reg_rd;
    end
    // ------------------------
    // Scenarios
    // ------------------------
    initial begin
        void'($urandom(32'h1B38A1AF));
        restart();
        wr(4'($urandom_range(4, 15)), 8'($urandom()));
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), `CPWT_REG_RST);
        end
        @(posedge clk);
        s = sys_taps;
        cyc(20);
        checkn("sys_taps", 16'(13'(s + 13'h0014)), 16'(sys_taps));
        checkn("sys tap", 16'(sys_taps[5]), 16'(timer_a_tap));
        for (int m = 0; m < 4; m++) begin
            wr(`CPWT_ADDR_MEDSEL, 8'(m));
            medium_speed <= 1'b1;
            @(posedge clk);
            s = sys_taps;
            cyc(128);
            checkn("medium steps", 16'(13'(s + 13'(8 >> m))), 16'(sys_taps));
        end
        medium_speed <= 1'b0;
        wr(`CPWT_ADDR_TMODE, 8'h0C);
        @(posedge clk);
        checkn("sub clear", 16'h0000, 16'(sub_taps));
        checkn("time base", 16'h0001, 16'(timer_a_time_base));
        checkn("timer a tap", 16'(sub_taps[1]), 16'(timer_a_tap));
        for (int sel = 0; sel < 8; sel++) begin
            wr(`CPWT_ADDR_SYSC1, {1'b0, 3'(sel), 4'h0});
            rd(`CPWT_ADDR_SYSC1, {1'b0, 3'(sel), 4'h0});
            settle_len     <= 5'($urandom_range(1, 20));
            low_power_mode <= 1'b1;
            @(posedge clk);
            s5 = sub_taps;
            cyc(96);
            checkn("sub in sleep", 16'(5'(s5 + 5'h04)), 16'(sub_taps));
            // Status while halted: hold, halt and the halted state code
            rd(`CPWT_ADDR_STATUS, 8'h0D);
            wake_accept    <= 1'b1;
            low_power_mode <= 1'b0;
            @(posedge clk);
            wake_accept <= 1'b0;
            wait_for(1'b1, n);
            wait_for(1'b0, n);
            checkn("hold cycles", 16'(len[sel] + 2), 16'(n));
        end
        low_power_mode <= 1'b1;
        cyc(4);
        restart();
        final_report();
    end
endmodule : cpwt_tb_top
